/* hw/csd_pkg.sv */
// shared types and constants for the raw field code decoder
package csd_pkg;

	// ------------------------------------------------------------
	// field types and logical states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CSD_T_UNDEF = 3'b000,
		CSD_T_BIT1 = 3'b001,
		CSD_T_BIT2 = 3'b010,
		CSD_T_BIT4 = 3'b011,
		CSD_T_BYTE1 = 3'b100,
		CSD_T_BYTE2 = 3'b101,
		CSD_T_BYTE4 = 3'b110
	} csd_type_t;

	typedef enum logic [1:0] {
		CSD_S_VALID = 2'b00,
		CSD_S_SPECIAL = 2'b01,
		CSD_S_ERROR = 2'b10,
		CSD_S_NA = 2'b11
	} csd_state_t;

	// value is unsigned q1.16, 1.0 = 0x10000
	typedef struct packed {
		csd_state_t state;
		logic [31:0] code;
		logic [16:0] value;
	} csd_result_t;

	typedef struct packed {
		csd_type_t tx_type;
		logic [2:0] bit_idx;
		logic [2:0] byte_idx;
		csd_type_t sig_type;
	} csd_cfg_t;

	// ------------------------------------------------------------
	// code ranges
	// ------------------------------------------------------------
	localparam logic [16:0] CSD_VAL_ONE = 17'h10000;
	localparam logic [31:0] CSD_D4_SPC = 32'h00000002;
	localparam logic [31:0] CSD_D4_ERR = 32'h0000000E;
	localparam logic [31:0] CSD_D4_NA = 32'h0000000F;
	localparam logic [31:0] CSD_D2_ERR = 32'h00000002;
	localparam logic [31:0] CSD_D2_NA = 32'h00000003;
	localparam logic [31:0] CSD_B1_SPC = 32'h000000FB;
	localparam logic [31:0] CSD_B1_ERR = 32'h000000FE;
	localparam logic [31:0] CSD_B1_NA = 32'h000000FF;
	localparam logic [31:0] CSD_B2_SPC = 32'h0000FB00;
	localparam logic [31:0] CSD_B2_ERR = 32'h0000FE00;
	localparam logic [31:0] CSD_B2_NA = 32'h0000FF00;
	localparam logic [31:0] CSD_B4_SPC = 32'hFB000000;
	localparam logic [31:0] CSD_B4_ERR = 32'hFE000000;
	localparam logic [31:0] CSD_B4_NA = 32'hFF000000;

	// ------------------------------------------------------------
	// register map (byte offsets) and reset values
	// ------------------------------------------------------------
	localparam logic [5:0] CSD_A_CTRL = 6'h00;
	localparam logic [5:0] CSD_A_RES = 6'h04;
	localparam logic [5:0] CSD_A_OFS = 6'h08;
	localparam logic [5:0] CSD_A_MAX = 6'h0C;
	localparam logic [5:0] CSD_A_MIN = 6'h10;
	localparam logic [5:0] CSD_A_STAT = 6'h14;
	localparam logic [5:0] CSD_A_CODE = 6'h18;
	localparam logic [5:0] CSD_A_VALUE = 6'h1C;
	localparam logic [5:0] CSD_A_TXCODE = 6'h20;
	localparam logic [5:0] CSD_A_RAW = 6'h24;
	localparam logic [5:0] CSD_A_IRQ_ST = 6'h28;
	localparam logic [5:0] CSD_A_IRQ_MSK = 6'h2C;
	localparam logic [31:0] CSD_CTRL_MASK = 32'h00007777;
	localparam logic [31:0] CSD_RES_RST = 32'h00000001;
	localparam logic [31:0] CSD_OFS_RST = 32'h00000000;
	localparam logic [31:0] CSD_MAX_RST = 32'h00000001;
	localparam logic [31:0] CSD_MIN_RST = 32'h00000000;
	localparam int CSD_IRQ_W = 4;
	localparam int CSD_IRQ_DONE = 0;
	localparam int CSD_IRQ_SPC = 1;
	localparam int CSD_IRQ_ERR = 2;
	localparam int CSD_IRQ_NA = 3;

endpackage

/* hw/csd_encoder.sv */
// transmit-side mapping of a logical signal back to a raw field code
`timescale 1ns/100ps
`default_nettype none

module csd_encoder
	import csd_pkg::*;
(
	input wire csd_type_t tx_type_i,
	input wire csd_state_t state_i,
	input wire logic [31:0] code_i,
	input wire logic [31:0] raw_i,
	output var logic [31:0] raw_code_o
);

	logic [31:0] vmax;
	logic [31:0] spc;
	logic [31:0] err;
	logic [31:0] na;
	logic [31:0] wmask;
	logic [31:0] emask;

	// ------------------------------------------------------------
	// range bases per target type
	// ------------------------------------------------------------
	// forms without a special range fall back to their nearest state
	always_comb begin
		vmax = 32'h00000001;
		spc = 32'h00000000;
		err = 32'h00000000;
		na = 32'h00000000;
		wmask = 32'h00000000;
		// only the wide forms have room for an error code
		emask = 32'h00000000;
		case (tx_type_i)
			CSD_T_BIT2: begin
				spc = CSD_D2_NA;
				err = CSD_D2_ERR;
				na = CSD_D2_NA;
				wmask = 32'h00000000;
			end
			CSD_T_BIT4: begin
				spc = CSD_D4_SPC;
				err = CSD_D4_ERR;
				na = CSD_D4_NA;
				wmask = 32'h0000000F;
			end
			CSD_T_BYTE1: begin
				vmax = CSD_B1_SPC - 32'h00000001;
				spc = CSD_B1_SPC;
				err = CSD_B1_ERR;
				na = CSD_B1_NA;
				wmask = 32'h00000003;
			end
			CSD_T_BYTE2: begin
				vmax = CSD_B2_SPC - 32'h00000001;
				spc = CSD_B2_SPC;
				err = CSD_B2_ERR;
				na = CSD_B2_NA;
				wmask = 32'h000003FF;
				emask = 32'h000000FF;
			end
			CSD_T_BYTE4: begin
				vmax = CSD_B4_SPC - 32'h00000001;
				spc = CSD_B4_SPC;
				err = CSD_B4_ERR;
				na = CSD_B4_NA;
				wmask = 32'h03FFFFFF;
				emask = 32'h00FFFFFF;
			end
			default: begin
				vmax = 32'h00000001;
			end
		endcase
	end

	// ------------------------------------------------------------
	// inverse mapping: base of the range plus the state code
	// ------------------------------------------------------------
	always_comb begin
		case (state_i)
			CSD_S_VALID: raw_code_o = (raw_i > vmax) ? vmax : raw_i;
			CSD_S_SPECIAL: raw_code_o = spc + (code_i & wmask);
			CSD_S_ERROR: raw_code_o = err + (code_i & emask);
			default: raw_code_o = na;
		endcase
		if (tx_type_i == CSD_T_UNDEF)
			raw_code_o = 32'h00000000;
	end

endmodule // csd_encoder

`default_nettype wire

/* hw/csd_decoder.sv */
// raw field code decoder with avalon-mm registers and retransmit code
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`default_nettype none

//Contract
// - A 1-bit field decodes codes 0 and 1 as valid, value equal to the code, state code zero.
// - A 2-bit field gives valid for 0 and 1, error for 2, not available for 3, state code zero.
// - A 4-bit field gives valid for 0-1, special code-2 for 2-13, error for 14, not available for 15.
// - A 1-byte field gives valid for 0-250, special code-251 for 251-253, error 254, n/a 255.
// - A 2-byte field splits at 64256, 65024 and 65280 with codes taken from each range base.
// - A 4-byte field splits at 0xFB, 0xFE and 0xFF top bytes with codes from each range base.
// - Any special, error or not available result carries a zero value.
// - Each decode yields state, value and state code; the code is zero for valid and n/a.
// - Special and error codes are relative: the range start is subtracted.
// - The encoder adds the range base of the chosen type to the state code.
// - Decode then encode keeps state and state code across field types; the code keeps them only where the target has the range and width.
// - Valid continuous codes are scaled by resolution and offset, then normalised min..max.
// - A byte position 1-8 picks the field start byte, a bit position 1-8 the discrete lsb; the code takes both as 0-7.
// - The type is undefined, one of three discrete or three continuous, undefined at reset.
module csd_decoder
	import csd_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic frame_valid_i,
	input wire logic [63:0] frame_data_i,
	output var logic dec_valid_o,
	output var csd_result_t dec_result_o,
	output var logic [31:0] tx_code_o,
	output var logic irq_o,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output var logic [31:0] avs_readdata_o,
	output var logic avs_waitrequest_o
);

	logic [31:0] ctrl_r;
	logic [31:0] res_r;
	logic [31:0] ofs_r;
	logic [31:0] max_r;
	logic [31:0] min_r;
	logic [31:0] raw_r;
	logic [CSD_IRQ_W-1:0] irq_st_r;
	logic [CSD_IRQ_W-1:0] irq_msk_r;
	logic [CSD_IRQ_W-1:0] irq_ev;
	logic [CSD_IRQ_W-1:0] irq_clr;
	csd_cfg_t cfg;
	logic wr_fire;
	logic [31:0] wmask;
	logic [31:0] rd_mux;
	logic [5:0] shift;
	logic [31:0] field;
	logic [31:0] cfield;
	logic signed [63:0] phys;
	logic signed [63:0] num;
	logic signed [63:0] den;
	logic [79:0] quo;
	logic [16:0] norm;
	csd_result_t dec_nxt;
	logic [31:0] enc_code;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [31:0] m);
		return (old & ~m) | (wd & m);
	endfunction

	// ------------------------------------------------------------
	// avalon-mm slave: one wait cycle for every access
	// ------------------------------------------------------------
	assign wr_fire = avs_write_i & ~avs_waitrequest_o;
	assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
		{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

	// waitrequest drops for exactly one cycle per request
	always_ff @(posedge clk_i) begin
		if (!resetn_i)
			avs_waitrequest_o <= 1'b1;
		else if ((avs_read_i | avs_write_i) && avs_waitrequest_o)
			avs_waitrequest_o <= 1'b0;
		else
			avs_waitrequest_o <= 1'b1;
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		case (avs_address_i)
			CSD_A_CTRL: rd_mux = ctrl_r;
			CSD_A_RES: rd_mux = res_r;
			CSD_A_OFS: rd_mux = ofs_r;
			CSD_A_MAX: rd_mux = max_r;
			CSD_A_MIN: rd_mux = min_r;
			CSD_A_STAT: rd_mux = {30'h0, dec_result_o.state};
			CSD_A_CODE: rd_mux = dec_result_o.code;
			CSD_A_VALUE: rd_mux = {15'h0, dec_result_o.value};
			CSD_A_TXCODE: rd_mux = tx_code_o;
			CSD_A_RAW: rd_mux = raw_r;
			CSD_A_IRQ_ST: rd_mux = {28'h0, irq_st_r};
			CSD_A_IRQ_MSK: rd_mux = {28'h0, irq_msk_r};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// read data stands from the edge that drops waitrequest
	always_ff @(posedge clk_i) begin
		if (!resetn_i)
			avs_readdata_o <= 32'h00000000;
		else if (avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= rd_mux;
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ctrl_r <= 32'h00000000;
			res_r <= CSD_RES_RST;
			ofs_r <= CSD_OFS_RST;
			max_r <= CSD_MAX_RST;
			min_r <= CSD_MIN_RST;
			irq_msk_r <= '0;
		end else if (wr_fire) begin
			case (avs_address_i)
				CSD_A_CTRL: ctrl_r <= merge(ctrl_r, avs_writedata_i, wmask)
					& CSD_CTRL_MASK;
				CSD_A_RES: res_r <= merge(res_r, avs_writedata_i, wmask);
				CSD_A_OFS: ofs_r <= merge(ofs_r, avs_writedata_i, wmask);
				CSD_A_MAX: max_r <= merge(max_r, avs_writedata_i, wmask);
				CSD_A_MIN: min_r <= merge(min_r, avs_writedata_i, wmask);
				CSD_A_IRQ_MSK: irq_msk_r <= CSD_IRQ_W'(merge({28'h0, irq_msk_r},
					avs_writedata_i, wmask));
				default: ;
			endcase
		end
	end

	assign cfg = '{tx_type: csd_type_t'(ctrl_r[14:12]),
		bit_idx: ctrl_r[10:8], byte_idx: ctrl_r[6:4],
		sig_type: csd_type_t'(ctrl_r[2:0])};

	// ------------------------------------------------------------
	// field extraction and normalisation
	// ------------------------------------------------------------
	// bit offset only applies to discrete fields
	always_comb begin
		shift = {cfg.byte_idx, 3'b000};
		if (cfg.sig_type == CSD_T_BIT1 || cfg.sig_type == CSD_T_BIT2
			|| cfg.sig_type == CSD_T_BIT4)
			shift = shift + {3'b000, cfg.bit_idx};
		field = 32'(frame_data_i >> shift);
		case (cfg.sig_type)
			CSD_T_BIT1: cfield = {31'h0, field[0]};
			CSD_T_BIT2: cfield = {30'h0, field[1:0]};
			CSD_T_BIT4: cfield = {28'h0, field[3:0]};
			CSD_T_BYTE1: cfield = {24'h0, field[7:0]};
			CSD_T_BYTE2: cfield = {16'h0, field[15:0]};
			default: cfield = field;
		endcase
	end

	// wide divider is the price of single-cycle latency
	always_comb begin
		phys = 64'({32'h0, cfield} * {{32{res_r[31]}}, res_r})
			+ {{32{ofs_r[31]}}, ofs_r};
		num = phys - {{32{min_r[31]}}, min_r};
		den = {{32{max_r[31]}}, max_r} - {{32{min_r[31]}}, min_r};
		quo = 80'h0;
		if (den <= 0 || num <= 0)
			norm = 17'h00000;
		else if (num >= den)
			norm = CSD_VAL_ONE;
		else begin
			quo = {num, 16'h0000} / {16'h0000, den};
			norm = quo[16:0];
		end
	end

	// ------------------------------------------------------------
	// range split per field type
	// ------------------------------------------------------------
	always_comb begin
		dec_nxt = '{state: CSD_S_NA, code: 32'h0, value: 17'h0};
		case (cfg.sig_type)
			CSD_T_BIT1: begin
				dec_nxt.state = CSD_S_VALID;
				dec_nxt.value = cfield[0] ? CSD_VAL_ONE : 17'h0;
			end
			CSD_T_BIT2: begin
				if (cfield < CSD_D2_ERR) begin
					dec_nxt.state = CSD_S_VALID;
					dec_nxt.value = cfield[0] ? CSD_VAL_ONE : 17'h0;
				end else if (cfield == CSD_D2_ERR)
					dec_nxt.state = CSD_S_ERROR;
			end
			CSD_T_BIT4: begin
				if (cfield < CSD_D4_SPC) begin
					dec_nxt.state = CSD_S_VALID;
					dec_nxt.value = cfield[0] ? CSD_VAL_ONE : 17'h0;
				end else if (cfield < CSD_D4_ERR) begin
					dec_nxt.state = CSD_S_SPECIAL;
					dec_nxt.code = cfield - CSD_D4_SPC;
				end else if (cfield == CSD_D4_ERR)
					dec_nxt.state = CSD_S_ERROR;
			end
			CSD_T_BYTE1: begin
				if (cfield < CSD_B1_SPC) begin
					dec_nxt.state = CSD_S_VALID;
					dec_nxt.value = norm;
				end else if (cfield < CSD_B1_ERR) begin
					dec_nxt.state = CSD_S_SPECIAL;
					dec_nxt.code = cfield - CSD_B1_SPC;
				end else if (cfield == CSD_B1_ERR)
					dec_nxt.state = CSD_S_ERROR;
			end
			CSD_T_BYTE2: begin
				if (cfield < CSD_B2_SPC) begin
					dec_nxt.state = CSD_S_VALID;
					dec_nxt.value = norm;
				end else if (cfield < CSD_B2_ERR) begin
					dec_nxt.state = CSD_S_SPECIAL;
					dec_nxt.code = cfield - CSD_B2_SPC;
				end else if (cfield < CSD_B2_NA) begin
					dec_nxt.state = CSD_S_ERROR;
					dec_nxt.code = cfield - CSD_B2_ERR;
				end
			end
			CSD_T_BYTE4: begin
				if (cfield < CSD_B4_SPC) begin
					dec_nxt.state = CSD_S_VALID;
					dec_nxt.value = norm;
				end else if (cfield < CSD_B4_ERR) begin
					dec_nxt.state = CSD_S_SPECIAL;
					dec_nxt.code = cfield - CSD_B4_SPC;
				end else if (cfield < CSD_B4_NA) begin
					dec_nxt.state = CSD_S_ERROR;
					dec_nxt.code = cfield - CSD_B4_ERR;
				end
			end
			default: dec_nxt.state = CSD_S_NA;
		endcase
		if (dec_nxt.state != CSD_S_VALID)
			dec_nxt.value = 17'h0;
	end

	// ------------------------------------------------------------
	// retransmit code and result registers
	// ------------------------------------------------------------
	csd_encoder u_enc (
		.tx_type_i(cfg.tx_type),
		.state_i(dec_nxt.state),
		.code_i(dec_nxt.code),
		.raw_i(cfield),
		.raw_code_o(enc_code)
	);

	// results hold until the next frame
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			dec_valid_o <= 1'b0;
			dec_result_o <= '{state: CSD_S_NA, code: 32'h0, value: 17'h0};
			tx_code_o <= 32'h00000000;
			raw_r <= 32'h00000000;
		end else begin
			dec_valid_o <= frame_valid_i;
			if (frame_valid_i) begin
				dec_result_o <= dec_nxt;
				tx_code_o <= enc_code;
				raw_r <= cfield;
			end
		end
	end

	// ------------------------------------------------------------
	// interrupts: sticky, write one to clear, set wins
	// ------------------------------------------------------------
	always_comb begin
		irq_ev = '0;
		irq_ev[CSD_IRQ_DONE] = frame_valid_i;
		irq_ev[CSD_IRQ_SPC] = frame_valid_i && dec_nxt.state == CSD_S_SPECIAL;
		irq_ev[CSD_IRQ_ERR] = frame_valid_i && dec_nxt.state == CSD_S_ERROR;
		irq_ev[CSD_IRQ_NA] = frame_valid_i && dec_nxt.state == CSD_S_NA;
		irq_clr = (wr_fire && avs_address_i == CSD_A_IRQ_ST)
			? CSD_IRQ_W'(avs_writedata_i & wmask) : '0;
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			irq_st_r <= '0;
			irq_o <= 1'b0;
		end else begin
			irq_st_r <= (irq_st_r & ~irq_clr) | irq_ev;
			irq_o <= |(((irq_st_r & ~irq_clr) | irq_ev) & irq_msk_r);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_frame(csd_type_t t);
		frame_valid_i && cfg.sig_type == t;
	endsequence

	property p_latency;
		frame_valid_i |=> dec_valid_o;
	endproperty
	a_latency: assert property (p_latency)
		else $error("decode not registered one cycle later");

	property p_bit1;
		s_frame(CSD_T_BIT1) |=> dec_result_o.state == CSD_S_VALID
			&& dec_result_o.code == 32'h0;
	endproperty
	a_bit1: assert property (p_bit1)
		else $error("1-bit field not valid");

	property p_bit2_err;
		s_frame(CSD_T_BIT2) ##0 (cfield == CSD_D2_ERR)
			|=> dec_result_o.state == CSD_S_ERROR;
	endproperty
	a_bit2_err: assert property (p_bit2_err)
		else $error("2-bit code 2 not error");

	property p_bit4_spc;
		s_frame(CSD_T_BIT4) ##0 (cfield >= CSD_D4_SPC && cfield < CSD_D4_ERR)
			|=> dec_result_o.state == CSD_S_SPECIAL
			&& dec_result_o.code == $past(cfield) - CSD_D4_SPC;
	endproperty
	a_bit4_spc: assert property (p_bit4_spc)
		else $error("4-bit special code wrong");

	property p_byte1_err;
		s_frame(CSD_T_BYTE1) ##0 (cfield == CSD_B1_ERR)
			|=> dec_result_o.state == CSD_S_ERROR;
	endproperty
	a_byte1_err: assert property (p_byte1_err)
		else $error("1-byte code 254 not error");

	property p_byte2_err;
		s_frame(CSD_T_BYTE2) ##0 (cfield[15:8] == 8'hFE)
			|=> dec_result_o.state == CSD_S_ERROR
			&& dec_result_o.code == $past(cfield) - CSD_B2_ERR;
	endproperty
	a_byte2_err: assert property (p_byte2_err)
		else $error("2-byte error code wrong");

	property p_byte4_na;
		s_frame(CSD_T_BYTE4) ##0 (cfield[31:24] == 8'hFF)
			|=> dec_result_o.state == CSD_S_NA && dec_result_o.code == 32'h0;
	endproperty
	a_byte4_na: assert property (p_byte4_na)
		else $error("4-byte top byte ff not n/a");

	property p_zero_value;
		dec_result_o.state != CSD_S_VALID |-> dec_result_o.value == 17'h0;
	endproperty
	a_zero_value: assert property (p_zero_value)
		else $error("non-valid state with nonzero value");

	property p_norm_range;
		dec_valid_o |-> dec_result_o.value <= CSD_VAL_ONE;
	endproperty
	a_norm_range: assert property (p_norm_range)
		else $error("value outside zero to one");

	property p_undef;
		s_frame(CSD_T_UNDEF) |=> dec_result_o.state == CSD_S_NA
			&& dec_result_o.value == 17'h0 && dec_result_o.code == 32'h0;
	endproperty
	a_undef: assert property (p_undef)
		else $error("undefined type not n/a");

	property p_round_trip;
		frame_valid_i && cfg.tx_type == cfg.sig_type
			&& cfg.sig_type >= CSD_T_BIT4
			&& dec_nxt.state inside {CSD_S_SPECIAL, CSD_S_ERROR}
			|=> tx_code_o == $past(cfield);
	endproperty
	a_round_trip: assert property (p_round_trip)
		else $error("retransmit code differs from received");

endmodule // csd_decoder

`default_nettype wire

/* test/csd_frame_src.sv */
// frame source model standing for the message receive path
`timescale 1ns/100ps
`default_nettype none

module csd_frame_src (
	input wire logic clk_i,
	input wire logic send_i,
	input wire logic [31:0] field_i,
	input wire logic [5:0] width_i,
	input wire logic [5:0] shift_i,
	output var logic frame_valid_o,
	output var logic [63:0] frame_data_o
);
	logic [63:0] mask;
	logic [63:0] fill = 64'h5A3C_96F0_0FE1_C3A5;

	// ------------------------------------------------------------
	// frame builder
	// ------------------------------------------------------------
	assign mask = ((64'h1 << width_i) - 64'h1) << shift_i;
	assign frame_data_o = fill;
	// bytes outside the field flip every cycle, so stale data never matches
	always @(posedge clk_i) begin
		frame_valid_o <= send_i;
		if (send_i) begin
			fill <= (~fill & ~mask)
				| ((64'(field_i) << shift_i) & mask);
		end else begin
			fill <= ~fill;
		end
	end
endmodule // csd_frame_src

`default_nettype wire

/* test/can_signal_code_decoder_tb.sv */
// self-checking bench for the raw field code decoder
`timescale 1ns/100ps
`default_nettype none

module can_signal_code_decoder_tb;
	import csd_pkg::*;
	logic clk = 0, resetn = 0, av_rd = 0, av_wr = 0, send = 0;
	logic [5:0] av_addr = 0, width = 8, shift = 0;
	logic [31:0] av_wdata = 0, field = 0, av_rdata, tx_code, q;
	logic [3:0] av_be = 4'hF;
	logic av_wait, dec_valid, irq, fv;
	logic [63:0] fd;
	csd_result_t res;
	int fail_count = 0, num_checks = 0;
	// bench copy of the scaling registers, kept in step with every write
	longint nres = CSD_RES_RST, nofs = CSD_OFS_RST;
	longint nmin = CSD_MIN_RST, nmax = CSD_MAX_RST;
	int wt[7] = '{8, 1, 2, 4, 8, 16, 32};

	csd_frame_src u_src (.clk_i(clk), .send_i(send), .field_i(field),
		.width_i(width), .shift_i(shift), .frame_valid_o(fv), .frame_data_o(fd));
	csd_decoder DUT (.clk_i(clk), .resetn_i(resetn), .frame_valid_i(fv),
		.frame_data_i(fd), .dec_valid_o(dec_valid), .dec_result_o(res),
		.tx_code_o(tx_code), .irq_o(irq), .avs_address_i(av_addr),
		.avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wdata),
		.avs_byteenable_i(av_be), .avs_readdata_o(av_rdata),
		.avs_waitrequest_o(av_wait));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	always #5 clk = ~clk;

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s exp %h seen %h", n, exp, seen);
		end
	endtask

	// one avalon transfer; the request holds until waitrequest is seen low
	task automatic avs(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		av_addr <= a;
		av_wr <= w;
		av_rd <= !w;
		av_wdata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (av_wait !== 1'b0 && n < 50);
		q = av_rdata;
		av_wr <= 0;
		av_rd <= 0;
		chk("bus answer", n < 50, 1);
	endtask

	// expected state and code, worked out from the range bases
	function automatic logic [33:0] exp_sc(input csd_type_t t, input logic [31:0] r);
		logic [31:0] s, e, n;
		case (t)
			CSD_T_BIT1: {s, e, n} = {3{32'h2}};
			CSD_T_BIT2: {s, e, n} = {CSD_D2_ERR, CSD_D2_ERR, CSD_D2_NA};
			CSD_T_BIT4: {s, e, n} = {CSD_D4_SPC, CSD_D4_ERR, CSD_D4_NA};
			CSD_T_BYTE1: {s, e, n} = {CSD_B1_SPC, CSD_B1_ERR, CSD_B1_NA};
			CSD_T_BYTE2: {s, e, n} = {CSD_B2_SPC, CSD_B2_ERR, CSD_B2_NA};
			CSD_T_BYTE4: {s, e, n} = {CSD_B4_SPC, CSD_B4_ERR, CSD_B4_NA};
			default: {s, e, n} = 96'h0;
		endcase
		if (r < s) return {CSD_S_VALID, 32'h0};
		if (r < e) return {CSD_S_SPECIAL, r - s};
		if (r < n) return {CSD_S_ERROR, r - e};
		return {CSD_S_NA, 32'h0};
	endfunction

	// configure, send one frame, judge the decode against the bench scaling
	task automatic dec(input csd_type_t t, input csd_type_t tx, input logic [2:0] bp,
		input logic [2:0] bi, input logic [31:0] r, input logic [31:0] etx);
		logic [33:0] e;
		logic [31:0] v;
		int n;
		longint nm;
		e = exp_sc(t, r);
		v = 0;
		nm = longint'(r) * nres + nofs - nmin;
		if (e[33:32] == CSD_S_VALID && t <= CSD_T_BIT4)
			v = (r == 1) ? 32'h10000 : 32'h0;
		else if (e[33:32] != CSD_S_VALID || nmax <= nmin || nm <= 0)
			v = 32'h0;
		else if (nm >= nmax - nmin)
			v = 32'h10000;
		else
			v = 32'((nm <<< 16) / (nmax - nmin));
		avs(1, CSD_A_CTRL, {17'h0, tx, 1'b0, bi, 1'b0, bp, 1'b0, t});
		@(posedge clk);
		field <= r;
		width <= 6'(wt[t]);
		shift <= 6'(bp * 8 + (t <= CSD_T_BIT4 ? bi : 0));
		send <= 1;
		@(posedge clk);
		send <= 0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (dec_valid !== 1'b1 && n < 20);
		chk("latency", n, 2);
		chk("state", res.state, e[33:32]);
		chk("code", res.code, e[31:0]);
		chk("value", {15'h0, res.value}, v);
		chk("tx code", tx_code, etx);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [5:0] a[8] = '{CSD_A_CTRL, CSD_A_RES, CSD_A_OFS, CSD_A_MAX,
			CSD_A_MIN, CSD_A_IRQ_ST, CSD_A_IRQ_MSK, 6'h3C};
		logic [31:0] x[8] = '{0, CSD_RES_RST, CSD_OFS_RST, CSD_MAX_RST,
			CSD_MIN_RST, 0, 0, 0};
		chk("reset state", res.state, CSD_S_NA);
		chk("reset irq", irq, 0);
		avs(1, 6'h3C, 32'hFFFF_FFFF);
		for (int i = 0; i < 8; i++) begin
			avs(0, a[i], 0);
			chk("reset reg", q, x[i]);
		end
		dec(CSD_T_UNDEF, CSD_T_UNDEF, 0, 0, 32'h5, 0);
		$display("test reset done");
	endtask

	task automatic t_disc();
		for (int r = 0; r < 2; r++) dec(CSD_T_BIT1, CSD_T_UNDEF, 2, 7, r, 0);
		for (int r = 0; r < 4; r++) dec(CSD_T_BIT2, CSD_T_UNDEF, 5, 6, r, 0);
		for (int r = 0; r < 16; r++) dec(CSD_T_BIT4, CSD_T_UNDEF, 7, 4, r, 0);
		$display("test discrete done");
	endtask

	task automatic t_cont();
		csd_type_t ty[3] = '{CSD_T_BYTE1, CSD_T_BYTE2, CSD_T_BYTE4};
		logic [2:0] bp[3] = '{7, 6, 4};
		logic [31:0] cv[3][8] = '{'{0, 1, 3, 250, 251, 253, 254, 255},
			'{2, 32'hFAFF, 32'hFB00, 32'hFDFF, 32'hFE00, 32'hFE07, 32'hFEFF, 32'hFF00},
			'{4, 32'hFAFFFFFF, 32'hFB000000, 32'hFB123456, 32'hFDFFFFFF,
			32'hFE000001, 32'hFEFFFFFF, 32'hFFFFFFFF}};
		avs(1, CSD_A_MAX, 4);
		nmax = 4;
		for (int i = 0; i < 3; i++)
			for (int j = 0; j < 8; j++) dec(ty[i], CSD_T_UNDEF, bp[i], 0, cv[i][j], 0);
		// scaled path: code*2+8 normalised over 10..74
		avs(1, CSD_A_RES, 2);
		avs(1, CSD_A_OFS, 8);
		avs(1, CSD_A_MIN, 10);
		avs(1, CSD_A_MAX, 74);
		nres = 2;
		nofs = 8;
		nmin = 10;
		nmax = 74;
		dec(CSD_T_BYTE1, CSD_T_UNDEF, 0, 0, 9, 0);
		dec(CSD_T_BYTE2, CSD_T_UNDEF, 1, 0, 2, 0);
		dec(CSD_T_BYTE1, CSD_T_UNDEF, 3, 0, 0, 0);
		dec(CSD_T_BYTE1, CSD_T_UNDEF, 3, 0, 40, 0);
		$display("test continuous done");
	endtask

	task automatic t_enc();
		dec(CSD_T_BYTE4, CSD_T_BYTE2, 0, 0, 32'hFE000001, 32'h0000FE01);
		dec(CSD_T_BIT4, CSD_T_BYTE4, 0, 0, 32'h3, 32'hFB000001);
		dec(CSD_T_BYTE2, CSD_T_BYTE1, 0, 0, 32'hFB01, 32'hFC);
		dec(CSD_T_BYTE2, CSD_T_BYTE2, 0, 0, 32'hFE07, 32'hFE07);
		dec(CSD_T_BYTE4, CSD_T_BYTE4, 0, 0, 32'hFB123456, 32'hFB123456);
		$display("test encode done");
	endtask

	// error is unmasked, not available stays masked
	task automatic t_irq();
		avs(1, CSD_A_IRQ_MSK, 1 << CSD_IRQ_ERR);
		avs(1, CSD_A_IRQ_ST, 32'hF);
		repeat (2) @(negedge clk);
		chk("irq idle", irq, 0);
		dec(CSD_T_BYTE1, CSD_T_UNDEF, 0, 0, 32'hFE, 0);
		repeat (2) @(negedge clk);
		chk("irq raised", irq, 1);
		avs(0, CSD_A_IRQ_ST, 0);
		chk("irq status", q, 32'h5);
		avs(1, CSD_A_IRQ_ST, 1 << CSD_IRQ_ERR);
		repeat (2) @(negedge clk);
		chk("irq cleared", irq, 0);
		dec(CSD_T_BYTE1, CSD_T_UNDEF, 0, 0, 32'hFF, 0);
		repeat (2) @(negedge clk);
		chk("irq masked", irq, 0);
		avs(0, CSD_A_IRQ_ST, 0);
		chk("irq status na", q, 32'h9);
		$display("test irq done");
	endtask

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// about 430 cycles expected; cut a hang well beyond that
	initial begin
		#100000;
		fail_count++;
		end_of_test();
	end

	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1;
		t_reset();
		t_disc();
		t_cont();
		t_enc();
		t_irq();
		end_of_test();
	end
endmodule // can_signal_code_decoder_tb

`default_nettype wire
